// ==== src/lsrt_core.sv ====
// Customer-end start-up and reset supervisor.
// Assumes receiver indications and service request are on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module lsrt_core #(
  parameter logic [31:0] START_CYC = lsrt_pkg::START_CYC,
  parameter logic [31:0] LOSS_CYC  = lsrt_pkg::LOSS_CYC,
  parameter logic [31:0] DWELL_CYC = lsrt_pkg::DWELL_CYC,
  parameter logic [31:0] REPLY_CYC = lsrt_pkg::REPLY_CYC,
  parameter logic [31:0] CTONE_CYC = lsrt_pkg::CTONE_CYC,
  parameter logic [31:0] SYM_CYC   = lsrt_pkg::SYM_CYC
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  input  wire lsrt_pkg::lsrt_rx_t rx_i,
  input  wire logic               svc_req_i,
  output lsrt_pkg::lsrt_tx_t      tx_o,
  output logic                    full_reset_o,
  output logic                    rx_reset_o,
  output logic                    active_o
);

  lsrt_pkg::lsrt_state_t state_q;
  lsrt_pkg::lsrt_state_t state_d;
  logic                  svc_q;
  logic                  svc_new;
  logic                  pwrup_q;
  logic                  tx_en_q;
  logic                  tone_sel_q;
  logic                  tone_high;
  logic [31:0]           dwell_lim;
  logic                  dwell_done;
  logic                  start_run;
  logic                  start_done;
  logic                  sig_run;
  logic                  sig_done;
  logic                  sync_run;
  logic                  sync_done;
  logic                  in_link;

  function automatic logic is_reset(lsrt_pkg::lsrt_state_t s);
    return (s == lsrt_pkg::ST_FULL) || (s == lsrt_pkg::ST_RXRST);
  endfunction : is_reset

  function automatic logic sends(lsrt_pkg::lsrt_state_t s);
    return (s == lsrt_pkg::ST_TONE) || (s == lsrt_pkg::ST_TRAIN) ||
           (s == lsrt_pkg::ST_ACTIVE);
  endfunction : sends

  // ****************************************
  // Requests
  // ****************************************
  assign svc_new = svc_req_i && !svc_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      svc_q <= 1'b0;
    end else begin
      svc_q <= svc_req_i;
    end
  end

  // Cold-start attempt pending after power-up
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pwrup_q <= 1'b1;
    end else if (state_q == lsrt_pkg::ST_TONE) begin
      pwrup_q <= 1'b0;
    end
  end

  // ****************************************
  // Timers
  // ****************************************
  assign in_link   = (state_q == lsrt_pkg::ST_TRAIN) ||
                     (state_q == lsrt_pkg::ST_ACTIVE);
  assign start_run = (state_q == lsrt_pkg::ST_TONE) ||
                     (state_q == lsrt_pkg::ST_AWAIT) ||
                     (state_q == lsrt_pkg::ST_TRAIN);
  assign sig_run   = in_link && !rx_i.sig_present;
  assign sync_run  = in_link && !rx_i.sync_lock;

  always_comb begin
    unique case (state_q)
      lsrt_pkg::ST_TONE:  dwell_lim = CTONE_CYC;
      lsrt_pkg::ST_AWAIT: dwell_lim = LOSS_CYC;
      default:            dwell_lim = DWELL_CYC;
    endcase
  end

  lsrt_timer #(.W(32)) u_dwell (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clear_i   (state_d != state_q),
    .run_i     (1'b1),
    .limit_i   (dwell_lim),
    .done_o    (dwell_done)
  );

  lsrt_timer #(.W(32)) u_start (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clear_i   (!start_run),
    .run_i     (start_run),
    .limit_i   (START_CYC),
    .done_o    (start_done)
  );

  lsrt_timer #(.W(32)) u_sig (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clear_i   (!sig_run),
    .run_i     (sig_run),
    .limit_i   (LOSS_CYC),
    .done_o    (sig_done)
  );

  lsrt_timer #(.W(32)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clear_i   (!sync_run),
    .run_i     (sync_run),
    .limit_i   (LOSS_CYC),
    .done_o    (sync_done)
  );

  // ****************************************
  // State machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lsrt_pkg::ST_FULL: begin
        if (rx_i.tone_det || svc_new || pwrup_q) begin
          state_d = lsrt_pkg::ST_TONE;
        end
      end
      lsrt_pkg::ST_TONE: begin
        if (dwell_done) begin
          state_d = lsrt_pkg::ST_AWAIT;
        end
      end
      lsrt_pkg::ST_AWAIT: begin
        if (rx_i.sig_present) begin
          state_d = lsrt_pkg::ST_TRAIN;
        end else if (dwell_done) begin
          state_d = lsrt_pkg::ST_FULL;
        end
      end
      lsrt_pkg::ST_TRAIN, lsrt_pkg::ST_ACTIVE: begin
        if (sig_done) begin
          state_d = lsrt_pkg::ST_RXRST;
        end else if (sync_done) begin
          state_d = lsrt_pkg::ST_SILENT;
        end else if (state_q == lsrt_pkg::ST_TRAIN && start_done) begin
          state_d = lsrt_pkg::ST_SILENT;
        end else if (state_q == lsrt_pkg::ST_TRAIN && rx_i.startup_done) begin
          state_d = lsrt_pkg::ST_ACTIVE;
        end
      end
      lsrt_pkg::ST_SILENT: begin
        if (!rx_i.sig_present) begin
          state_d = lsrt_pkg::ST_RXRST;
        end
      end
      lsrt_pkg::ST_RXRST: begin
        if (rx_i.tone_det) begin
          state_d = lsrt_pkg::ST_TONE;
        end else if (dwell_done) begin
          state_d = lsrt_pkg::ST_FULL;
        end
      end
      default: state_d = lsrt_pkg::ST_FULL;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= lsrt_pkg::ST_FULL;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_en_q      <= 1'b0;
      tone_sel_q   <= 1'b0;
      full_reset_o <= 1'b1;
      rx_reset_o   <= 1'b0;
      active_o     <= 1'b0;
    end else begin
      tx_en_q      <= sends(state_d);
      tone_sel_q   <= (state_d == lsrt_pkg::ST_TONE);
      full_reset_o <= (state_d == lsrt_pkg::ST_FULL);
      rx_reset_o   <= (state_d == lsrt_pkg::ST_RXRST);
      active_o     <= (state_d == lsrt_pkg::ST_ACTIVE);
    end
  end

  lsrt_tone_gen #(.SYM_CYC(SYM_CYC)) u_tone (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .en_i      (tone_sel_q),
    .high_o    (tone_high)
  );

  always_comb begin
    tx_o.tx_en     = tx_en_q;
    tx_o.tone_sel  = tone_sel_q;
    tx_o.tone_high = tone_high;
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [31:0] reply_cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tone_sel_q || !rx_i.tone_det) begin
      reply_cnt_q <= '0;
    end else if (reply_cnt_q != 32'hffffffff) begin
      reply_cnt_q <= reply_cnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  reply_bound_a: assert property (reply_cnt_q < REPLY_CYC)
    else $error("Tone reply later than allowed");

  tone_answer_a: assert property (
    (is_reset(state_q) && rx_i.tone_det) |=> ##1 tx_o.tone_sel && tx_o.tx_en)
    else $error("Network tone not answered");

  sig_loss_a: assert property (in_link && sig_done |=>
    state_q == lsrt_pkg::ST_RXRST ##1 !tx_o.tx_en && rx_reset_o)
    else $error("Signal loss did not reach receive reset");

  sync_loss_a: assert property (
    in_link && sync_done && !sig_done |=> state_q == lsrt_pkg::ST_SILENT
    ##1 !tx_o.tx_en && !rx_reset_o)
    else $error("Sync loss did not silence transmitter");

  no_early_reset_a: assert property (
    $past(in_link) && state_q == lsrt_pkg::ST_RXRST |-> $past(sig_done))
    else $error("Reset entered before loss timer expired");

  silent_exit_a: assert property (
    state_q == lsrt_pkg::ST_SILENT && !rx_i.sig_present |=>
    state_q == lsrt_pkg::ST_RXRST)
    else $error("Silenced end missed far-end silence");

  rx_dwell_a: assert property (
    state_q == lsrt_pkg::ST_RXRST && !dwell_done && !rx_i.tone_det |=>
    state_q == lsrt_pkg::ST_RXRST)
    else $error("Receive reset left before dwell");

  rx_exit_a: assert property (
    state_q == lsrt_pkg::ST_RXRST && dwell_done && !rx_i.tone_det |=>
    state_q == lsrt_pkg::ST_FULL ##1 full_reset_o)
    else $error("Receive reset did not fall to full reset");

  await_timeout_a: assert property (
    state_q == lsrt_pkg::ST_AWAIT && dwell_done && !rx_i.sig_present |=>
    state_q == lsrt_pkg::ST_FULL)
    else $error("No full reset after silent wait");

  startup_timeout_a: assert property (
    state_q == lsrt_pkg::ST_TRAIN && start_done |=> ##1 !tx_o.tx_en)
    else $error("Start-up timeout ignored");

  quiet_reset_a: assert property (
    state_q == lsrt_pkg::ST_FULL && !rx_i.tone_det && !svc_new && !pwrup_q
    |=> state_q == lsrt_pkg::ST_FULL)
    else $error("Full reset left without cause");

  service_req_a: assert property (
    state_q == lsrt_pkg::ST_FULL && svc_new |=> state_q == lsrt_pkg::ST_TONE)
    else $error("Service request not answered with tone");

  powerup_a: assert property (
    $fell(rst_i) |-> state_q == lsrt_pkg::ST_FULL && full_reset_o)
    else $error("Not in full reset after power-up");

  cold_start_a: assert property (
    state_q == lsrt_pkg::ST_FULL && pwrup_q |=> state_q == lsrt_pkg::ST_TONE)
    else $error("Cold-start attempt not made");

  cold_start_c: cover property (state_q == lsrt_pkg::ST_FULL && pwrup_q
    ##1 state_q == lsrt_pkg::ST_TONE);
  reach_active_c: cover property (state_q == lsrt_pkg::ST_ACTIVE);
  sync_loss_c: cover property (state_q == lsrt_pkg::ST_SILENT
    ##1 state_q == lsrt_pkg::ST_RXRST);
  rx_tone_c: cover property (state_q == lsrt_pkg::ST_RXRST && rx_i.tone_det);
  signal_back_c: cover property (state_q == lsrt_pkg::ST_AWAIT
    ##1 state_q == lsrt_pkg::ST_TRAIN);

endmodule : lsrt_core

`default_nettype wire

// ==== src/lsrt_pkg.sv ====
// Constants, state and carrier types for the loop start-up and reset timers.
// Assumes one 250 MHz system clock and receiver indications on that clock.

package lsrt_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned CLK_HZ         = 64'd250_000_000;
  localparam longint unsigned START_LIMIT_S  = 64'd15;
  localparam longint unsigned LOSS_LIMIT_MS  = 64'd480;
  localparam longint unsigned RXRST_DWELL_MS = 64'd40;
  localparam longint unsigned REPLY_LIMIT_MS = 64'd4;
  localparam longint unsigned SYM_RATE_BD    = 64'd80_000;
  localparam longint unsigned CTONE_FRAMES   = 64'd6;
  localparam longint unsigned FRAME_SYMS     = 64'd120;

  localparam logic [31:0] START_CYC = 32'(START_LIMIT_S * CLK_HZ);
  localparam logic [31:0] LOSS_CYC  =
    32'((LOSS_LIMIT_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam logic [31:0] DWELL_CYC =
    32'((RXRST_DWELL_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam logic [31:0] REPLY_CYC = 32'((REPLY_LIMIT_MS * CLK_HZ) / 64'd1000);
  localparam logic [31:0] SYM_CYC   = 32'(CLK_HZ / SYM_RATE_BD);
  localparam logic [31:0] CTONE_CYC =
    32'((CTONE_FRAMES * FRAME_SYMS * CLK_HZ) / SYM_RATE_BD);

  // ****************************************
  // Tone shape
  // ****************************************
  localparam logic [2:0] TONE_HALF = 3'h4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_FULL,
    ST_TONE,
    ST_AWAIT,
    ST_TRAIN,
    ST_ACTIVE,
    ST_SILENT,
    ST_RXRST
  } lsrt_state_t;

  typedef struct packed {
    logic sig_present;
    logic sync_lock;
    logic tone_det;
    logic startup_done;
  } lsrt_rx_t;

  typedef struct packed {
    logic tx_en;
    logic tone_sel;
    logic tone_high;
  } lsrt_tx_t;

endpackage : lsrt_pkg

// ==== src/lsrt_timer.sv ====
// Saturating interval counter.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module lsrt_timer #(
  parameter int W = 32
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         clear_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] limit_i,
  output logic              done_o
);

  logic [W-1:0] cnt_q;

  // ****************************************
  // Count
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || clear_i) begin
      cnt_q <= '0;
    end else if (run_i && cnt_q < limit_i) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign done_o = (cnt_q >= limit_i);

endmodule : lsrt_timer

`default_nettype wire

// ==== src/lsrt_tone_gen.sv ====
// Wake-up tone symbol sequencer.
// Assumes enable from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module lsrt_tone_gen #(
  parameter logic [31:0] SYM_CYC = lsrt_pkg::SYM_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output logic      high_o
);

  logic [31:0] div_q;
  logic [2:0]  idx_q;

  // ****************************************
  // Symbol pacing
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !en_i) begin
      div_q <= '0;
      idx_q <= '0;
    end else if (div_q == SYM_CYC - 32'h1) begin
      div_q <= '0;
      idx_q <= idx_q + 3'h1;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // Four +3 then four -3
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      high_o <= 1'b0;
    end else begin
      high_o <= en_i && (idx_q < lsrt_pkg::TONE_HALF);
    end
  end

endmodule : lsrt_tone_gen

`default_nettype wire

// ==== testbench/lsrt_peer.sv ====
// Behavioural network-end transceiver facing the customer-end supervisor.
// Assumes bench commands and DUT transmit controls on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module lsrt_peer #(
  parameter int NTONE_CYC = 40
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  input  wire lsrt_pkg::lsrt_tx_t tx_i,
  input  wire logic               act_req_i,
  input  wire logic               coop_i,
  input  wire logic               sync_ok_i,
  input  wire logic               done_ok_i,
  output lsrt_pkg::lsrt_rx_t      rx_o
);
  // ********
  // Tone and signal
  // ********
  logic heard_q;
  logic sig_q;
  logic act_q;
  int   tone_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      heard_q <= 1'b0;
      sig_q   <= 1'b0;
      act_q   <= 1'b0;
      tone_q  <= 0;
    end else begin
      act_q <= act_req_i;
      if (act_req_i && !act_q) begin
        tone_q <= NTONE_CYC;
      end else if (tone_q > 0) begin
        tone_q <= tone_q - 1;
      end
      if (tx_i.tx_en && tx_i.tone_sel) begin
        heard_q <= 1'b1;
      end else if (sig_q || !coop_i) begin
        heard_q <= 1'b0;
      end
      sig_q <= coop_i && (sig_q || (heard_q && !tx_i.tx_en));
    end
  end

  always_comb begin
    rx_o.sig_present  = sig_q;
    rx_o.tone_det     = (tone_q > 0);
    rx_o.sync_lock    = sig_q && sync_ok_i;
    rx_o.startup_done = sig_q && sync_ok_i && done_ok_i;
  end
endmodule : lsrt_peer
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the customer-end start-up and reset supervisor.
// Assumes shortened timer parameters and the behavioural peer model.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int ST = 32'h0000_07d0;
  localparam int LOSS = 32'h0000_00c8;
  localparam int DWELL = 32'h0000_0032;
  localparam int REPLY = 32'h0000_0014;
  localparam int CTONE = 32'h0000_0064;
  localparam int SYM = 32'h0000_0004;
  localparam int TXEN = 0, TSEL = 1, THI = 2, FULL = 3, RXR = 4, ACT = 5;

  logic               sys_clk_i;
  logic               rst_i;
  logic               svc_req_i;
  logic               act_req;
  logic               coop;
  logic               sync_ok;
  logic               done_ok;
  lsrt_pkg::lsrt_rx_t rx;
  lsrt_pkg::lsrt_tx_t tx;
  logic               full_rst;
  logic               rx_rst;
  logic               active;
  int                 miscompares;
  int                 check_count;
  int                 n;
  int                 m;
  int                 k;

  lsrt_core #(
    .START_CYC (32'(ST)),
    .LOSS_CYC  (32'(LOSS)),
    .DWELL_CYC (32'(DWELL)),
    .REPLY_CYC (32'(REPLY)),
    .CTONE_CYC (32'(CTONE)),
    .SYM_CYC   (32'(SYM))
  ) DUT (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .rx_i         (rx),
    .svc_req_i    (svc_req_i),
    .tx_o         (tx),
    .full_reset_o (full_rst),
    .rx_reset_o   (rx_rst),
    .active_o     (active)
  );

  lsrt_peer peer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tx_i      (tx),
    .act_req_i (act_req),
    .coop_i    (coop),
    .sync_ok_i (sync_ok),
    .done_ok_i (done_ok),
    .rx_o      (rx)
  );

  // ********
  // Checking helpers
  // ********
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_span(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got,
               lo, hi);
    end
  endtask : cmp_span

  function automatic logic pick(input int s);
    case (s)
      TXEN:    return tx.tx_en;
      TSEL:    return tx.tone_sel;
      THI:     return tx.tone_high;
      FULL:    return full_rst;
      RXR:     return rx_rst;
      default: return active;
    endcase
  endfunction : pick

  task automatic wait_for(input int s, input logic v, input int bound,
                          output int cnt);
    cnt = 0;
    while (pick(s) !== v) begin
      if (cnt >= bound) begin
        miscompares++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, pick(s),
                 v);
        give_verdict();
      end
      @(posedge sys_clk_i);
      #1;
      cnt++;
    end
  endtask : wait_for

  task automatic hold_low(input int s, input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge sys_clk_i);
      #1;
      seen = seen | pick(s);
    end
    cmp_bit(seen, 1'b0);
  endtask : hold_low

  // ********
  // Scenarios
  // ********
  task automatic t_powerup();
    cmp_bit(full_rst, 1'b1);
    cmp_bit(tx.tx_en, 1'b0);
    wait_for(TSEL, 1'b1, 5, n);
    wait_for(THI, 1'b1, 40, n);
    wait_for(THI, 1'b0, 40, n);
    cmp_span(n, 4 * SYM, 4 * SYM);
    wait_for(THI, 1'b1, 40, n);
    cmp_span(n, 4 * SYM, 4 * SYM);
    wait_for(TXEN, 1'b0, CTONE, n);
    wait_for(FULL, 1'b1, 400, n);
    cmp_span(n, LOSS - 3, LOSS + 3);
    hold_low(TXEN, 300);
  endtask : t_powerup

  task automatic t_svc_loss();
    @(posedge sys_clk_i);
    coop      <= 1'b1;
    sync_ok   <= 1'b1;
    done_ok   <= 1'b1;
    svc_req_i <= 1'b1;
    wait_for(TSEL, 1'b1, 5, n);
    wait_for(ACT, 1'b1, 600, n);
    cmp_bit(tx.tone_sel, 1'b0);
    @(posedge sys_clk_i);
    svc_req_i <= 1'b0;
    coop      <= 1'b0;
    wait_for(RXR, 1'b1, 400, n);
    cmp_span(n, LOSS - 1, LOSS + 5);
    cmp_bit(tx.tx_en, 1'b0);
    wait_for(FULL, 1'b1, 200, n);
    cmp_span(n, DWELL - 1, DWELL + 3);
  endtask : t_svc_loss

  task automatic t_net_sync();
    @(posedge sys_clk_i);
    coop    <= 1'b1;
    act_req <= 1'b1;
    wait_for(TSEL, 1'b1, REPLY, n);
    wait_for(ACT, 1'b1, 600, n);
    @(posedge sys_clk_i);
    act_req <= 1'b0;
    sync_ok <= 1'b0;
    wait_for(TXEN, 1'b0, 400, n);
    cmp_span(n, LOSS - 1, LOSS + 5);
    hold_low(RXR, 30);
    @(posedge sys_clk_i);
    coop <= 1'b0;
    wait_for(RXR, 1'b1, DWELL, n);
    @(posedge sys_clk_i);
    act_req <= 1'b1;
    wait_for(TSEL, 1'b1, REPLY, n);
    cmp_bit(full_rst, 1'b0);
    wait_for(FULL, 1'b1, 600, n);
    @(posedge sys_clk_i);
    act_req <= 1'b0;
    sync_ok <= 1'b1;
  endtask : t_net_sync

  task automatic t_timeout();
    @(posedge sys_clk_i);
    coop      <= 1'b1;
    done_ok   <= 1'b0;
    svc_req_i <= 1'b1;
    wait_for(TSEL, 1'b1, 5, n);
    wait_for(TSEL, 1'b0, CTONE + 5, n);
    wait_for(TXEN, 1'b1, 20, m);
    wait_for(TXEN, 1'b0, ST, k);
    cmp_span(n + m + k, ST - 3, ST + 3);
    hold_low(RXR, 30);
    @(posedge sys_clk_i);
    coop      <= 1'b0;
    svc_req_i <= 1'b0;
    wait_for(FULL, 1'b1, 400, n);
  endtask : t_timeout

  // ********
  // Clock and main sequence
  // ********
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    rst_i       = 1'b1;
    svc_req_i   = 1'b0;
    act_req     = 1'b0;
    coop        = 1'b0;
    sync_ok     = 1'b0;
    done_ok     = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    t_powerup();
    t_svc_loss();
    t_net_sync();
    t_timeout();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
